// file: shared/asd_pkg.sv
// Functional notes
// - Overflow-select opcode arms the flag on carry-in XOR carry-out of the top bit.
// - First near-overflow opcode arms the flag within a factor of two of overflow.
// - Second near-overflow opcode arms the flag within a factor of four of overflow.
// - Zero-select opcode arms the flag on zero result; flag rises during it.
// - Any flag-programming opcode forces the ALU result to zero.
// - Constant-one and low-byte-mask opcodes output their fixed 16-bit patterns.
// - Nibble-mask and alternating-pattern opcodes output their fixed 16-bit patterns.
// - Shifter code 0 shifts right logically by the port count.
// - Shifter code 1 shifts left logically by the port count.
// - Shifter code 2 rotates right by the port count.
// - A shifter code rotates left by the port count.
// - A shifter code shifts right logically by count register A.
// - Codes 8 and 9 load count register A or B from the port; data passes.
// - Codes A, B, C shift right arithmetically by port, A or B count.
// - Normalise shifts left by the leading sign-bit count, at most 15.
// - Codes E and F normalise and also store the count in register A or B.
// - Normalise drives its count on the port only while the enable pin is low.
// - Register codes 0 and 1 show right or left and load the other.
// - Register codes 2 and 3 show and load left or right respectively.
// - Register code 4 shows left and loads both registers.
// - Register codes 5 and 6 show right or left and load nothing.
// - Register code 7 passes its input straight through and loads nothing.
// - Instructions are latched on a rising edge and execute in the next cycle.
// - Two independent two-register files, one for the ALU, one for the shifter.
// - With the enable pin high the shift-value port is never driven.
package asd_pkg;
	localparam int DATA_W = 16;
	localparam int ALU_OP_W = 5;
	localparam int SHF_OP_W = 4;
	localparam int RF_OP_W = 3;
	localparam int CNT_W = 4;

	// ALU control opcodes handled in this block; lower codes come from the arithmetic core.
	localparam logic [4:0] ALU_FLAG_SEL_OVERFLOW = 5'h18;
	localparam logic [4:0] ALU_FLAG_SEL_NEAR_OVF_X2 = 5'h19;
	localparam logic [4:0] ALU_FLAG_SEL_NEAR_OVF_X4 = 5'h1a;
	localparam logic [4:0] ALU_FLAG_SEL_ZERO = 5'h1b;
	localparam logic [4:0] ALU_CONST_ONE = 5'h1c;
	localparam logic [4:0] ALU_CONST_LOW_BYTE_MASK = 5'h1d;
	localparam logic [4:0] ALU_CONST_NIBBLE_MASK = 5'h1e;
	localparam logic [4:0] ALU_CONST_ALTERNATING = 5'h1f;

	localparam logic [15:0] VAL_CONST_ONE = 16'h0001;
	localparam logic [15:0] VAL_LOW_BYTE_MASK = 16'h00ff;
	localparam logic [15:0] VAL_NIBBLE_MASK = 16'h000f;
	localparam logic [15:0] VAL_ALTERNATING = 16'h5555;

	// Barrel shifter opcodes.
	localparam logic [3:0] SHF_LOGICAL_RIGHT_BY_PORT_COUNT = 4'h0;
	localparam logic [3:0] SHF_SHIFT_LEFT_BY_PORT_COUNT = 4'h1;
	localparam logic [3:0] SHF_ROTATE_RIGHT_BY_PORT_COUNT = 4'h2;
	localparam logic [3:0] SHF_ROTATE_LEFT_BY_PORT_COUNT = 4'h3;
	localparam logic [3:0] SHF_LOGICAL_RIGHT_BY_COUNT_A = 4'h4;
	localparam logic [3:0] SHF_LOAD_COUNT_A_FROM_PORT = 4'h8;
	localparam logic [3:0] SHF_LOAD_COUNT_B_FROM_PORT = 4'h9;
	localparam logic [3:0] SHF_ARITH_RIGHT_BY_PORT_COUNT = 4'ha;
	localparam logic [3:0] SHF_ARITH_RIGHT_BY_COUNT_A = 4'hb;
	localparam logic [3:0] SHF_ARITH_RIGHT_BY_COUNT_B = 4'hc;
	localparam logic [3:0] SHF_NORMALISE_ONLY = 4'hd;
	localparam logic [3:0] SHF_NORMALISE_SAVE_COUNT_A = 4'he;
	localparam logic [3:0] SHF_NORMALISE_SAVE_COUNT_B = 4'hf;

	// Register-file opcodes, shared by both files.
	localparam logic [2:0] RF_LOAD_LEFT_SHOW_RIGHT = 3'h0;
	localparam logic [2:0] RF_LOAD_RIGHT_SHOW_LEFT = 3'h1;
	localparam logic [2:0] RF_LOAD_LEFT_SHOW_LEFT = 3'h2;
	localparam logic [2:0] RF_LOAD_RIGHT_SHOW_RIGHT = 3'h3;
	localparam logic [2:0] RF_LOAD_BOTH_SHOW_LEFT = 3'h4;
	localparam logic [2:0] RF_HOLD_SHOW_RIGHT = 3'h5;
	localparam logic [2:0] RF_HOLD_SHOW_LEFT = 3'h6;
	localparam logic [2:0] RF_HOLD_PASS_THROUGH = 3'h7;
	localparam logic [2:0] RF_RESET_INSTR = RF_HOLD_SHOW_LEFT;

	localparam logic [15:0] RESET_DATA = 16'h0000;
	localparam logic [3:0] RESET_COUNT = 4'h0;
	localparam logic [3:0] RESET_SHF_INSTR = SHF_LOAD_COUNT_A_FROM_PORT;

	// Flag source modes.
	typedef enum logic [3:0] {
		ASD_FLAG_OVERFLOW = 4'b0001,
		ASD_FLAG_NEAR_OVF_X2 = 4'b0010,
		ASD_FLAG_NEAR_OVF_X4 = 4'b0100,
		ASD_FLAG_ZERO = 4'b1000
	} asd_flag_mode_type;

	// AHB-Lite register map.
	localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
	localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
	localparam int CTRL_DRIVE_ALLOW_BIT = 0;
	localparam logic CTRL_DRIVE_ALLOW_RESET = 1'b1;
	localparam int STAT_SV_LSB = 0;
	localparam int STAT_COUNT_A_LSB = 4;
	localparam int STAT_COUNT_B_LSB = 8;
	localparam int STAT_FLAG_MODE_LSB = 12;
	localparam int STAT_FLAG_BIT = 16;
	localparam int STAT_SV_DRIVE_BIT = 17;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
endpackage

// file: src/asd_alu_shifter.sv
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
// ALU control decode, barrel shifter and both register files, with an AHB-Lite status port.
module asd_alu_shifter (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [4:0] alu_instr,
	input wire logic [3:0] shift_instr,
	input wire logic [2:0] alu_rf_instr,
	input wire logic [2:0] shift_rf_instr,
	input wire logic [15:0] alu_core_result,
	input wire logic alu_core_carry_into_msb,
	input wire logic alu_core_carry_out,
	input wire logic [15:0] shift_in,
	input wire logic [3:0] shift_value_port_in,
	output logic [3:0] shift_value_port_out,
	output logic shift_value_port_oe,
	input wire logic shift_value_out_enable_n,
	output logic [15:0] alu_rf_out,
	output logic [15:0] shift_rf_out,
	output logic condition_flag_out,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);
	asd_pkg::asd_flag_mode_type flag_mode;
	asd_pkg::asd_flag_mode_type next_flag_mode;
	logic [15:0] alu_result_q;
	logic [15:0] next_alu_result;
	logic next_overflow;
	logic next_flag;
	logic [15:0] shift_result_q;
	logic [15:0] next_shift_result;
	logic [3:0] shift_ir;
	logic [2:0] alu_rf_ir;
	logic [2:0] shift_rf_ir;
	logic [3:0] sv_reg;
	logic [3:0] norm_count_q;
	logic [3:0] next_norm_count;
	logic [3:0] shift_count_reg_a;
	logic [3:0] shift_count_reg_b;
	logic [3:0] next_count_a;
	logic [3:0] next_count_b;
	logic [3:0] shift_amount;
	logic [31:0] rot_right_word;
	logic [31:0] rot_left_word;
	logic is_normalise;
	logic ctrl_drive_allow;
	logic wr_pending;
	logic [31:0] wr_addr;
	logic [31:0] read_value;
	logic ctrl_view;
	logic bus_read_req;
	logic bus_write_req;

	// Counts the run of bits under the sign bit that equal it; zero or all ones give 15.
	function automatic logic [3:0] norm_count(input logic [15:0] v);
		logic [3:0] n;
		logic run;
		n = 4'h0;
		run = 1'b1;
		for (int i = 14; i >= 0; i--) begin
			if (run && (v[i] == v[15])) begin
				n = n + 4'h1;
			end else begin
				run = 1'b0;
			end
		end
		return n;
	endfunction

	// ALU control decode for the instruction being latched at this edge.
	always_comb begin
		next_alu_result = alu_core_result;
		next_overflow = alu_core_carry_into_msb ^ alu_core_carry_out;
		next_flag_mode = flag_mode;
		unique case (alu_instr)
			asd_pkg::ALU_FLAG_SEL_OVERFLOW: begin
				next_flag_mode = asd_pkg::ASD_FLAG_OVERFLOW;
				next_alu_result = asd_pkg::RESET_DATA;
				next_overflow = 1'b0;
			end
			asd_pkg::ALU_FLAG_SEL_NEAR_OVF_X2: begin
				next_flag_mode = asd_pkg::ASD_FLAG_NEAR_OVF_X2;
				next_alu_result = asd_pkg::RESET_DATA;
				next_overflow = 1'b0;
			end
			asd_pkg::ALU_FLAG_SEL_NEAR_OVF_X4: begin
				next_flag_mode = asd_pkg::ASD_FLAG_NEAR_OVF_X4;
				next_alu_result = asd_pkg::RESET_DATA;
				next_overflow = 1'b0;
			end
			asd_pkg::ALU_FLAG_SEL_ZERO: begin
				next_flag_mode = asd_pkg::ASD_FLAG_ZERO;
				next_alu_result = asd_pkg::RESET_DATA;
				next_overflow = 1'b0;
			end
			asd_pkg::ALU_CONST_ONE: begin
				next_alu_result = asd_pkg::VAL_CONST_ONE;
				next_overflow = 1'b0;
			end
			asd_pkg::ALU_CONST_LOW_BYTE_MASK: begin
				next_alu_result = asd_pkg::VAL_LOW_BYTE_MASK;
				next_overflow = 1'b0;
			end
			asd_pkg::ALU_CONST_NIBBLE_MASK: begin
				next_alu_result = asd_pkg::VAL_NIBBLE_MASK;
				next_overflow = 1'b0;
			end
			asd_pkg::ALU_CONST_ALTERNATING: begin
				next_alu_result = asd_pkg::VAL_ALTERNATING;
				next_overflow = 1'b0;
			end
			default: begin
				next_flag_mode = flag_mode;
			end
		endcase
	end

	// The flag uses the newly armed mode, so a zero-select raises it during its own cycle.
	always_comb begin
		unique case (next_flag_mode)
			asd_pkg::ASD_FLAG_OVERFLOW: next_flag = next_overflow;
			asd_pkg::ASD_FLAG_NEAR_OVF_X2: next_flag = next_overflow
				| (next_alu_result[15] ^ next_alu_result[14]);
			asd_pkg::ASD_FLAG_NEAR_OVF_X4: next_flag = next_overflow
				| (next_alu_result[15] ^ next_alu_result[14])
				| (next_alu_result[15] ^ next_alu_result[13]);
			asd_pkg::ASD_FLAG_ZERO: next_flag = (next_alu_result == asd_pkg::RESET_DATA);
			default: next_flag = next_overflow;
		endcase
	end

	// Flag mode and ALU result of the executing instruction.
	// The flag is registered with the result, so both change on the same edge.
	// A mode armed here stays in force until another flag-programming opcode arrives.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_mode <= asd_pkg::ASD_FLAG_OVERFLOW;
			alu_result_q <= asd_pkg::RESET_DATA;
			condition_flag_out <= 1'b0;
		end else begin
			flag_mode <= next_flag_mode;
			alu_result_q <= next_alu_result;
			condition_flag_out <= next_flag;
		end
	end

	// Instruction and shift-value latches; execution follows in the next cycle.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_ir <= asd_pkg::RESET_SHF_INSTR;
			alu_rf_ir <= asd_pkg::RF_RESET_INSTR;
			shift_rf_ir <= asd_pkg::RF_RESET_INSTR;
			sv_reg <= asd_pkg::RESET_COUNT;
			norm_count_q <= asd_pkg::RESET_COUNT;
		end else begin
			shift_ir <= shift_instr;
			alu_rf_ir <= alu_rf_instr;
			shift_rf_ir <= shift_rf_instr;
			sv_reg <= shift_value_port_in;
			norm_count_q <= next_norm_count;
		end
	end

	// Count registers load at the closing edge of the executing instruction.
	always_comb begin
		next_count_a = shift_count_reg_a;
		next_count_b = shift_count_reg_b;
		unique case (shift_ir)
			asd_pkg::SHF_LOAD_COUNT_A_FROM_PORT: next_count_a = sv_reg;
			asd_pkg::SHF_LOAD_COUNT_B_FROM_PORT: next_count_b = sv_reg;
			asd_pkg::SHF_NORMALISE_SAVE_COUNT_A: next_count_a = norm_count_q;
			asd_pkg::SHF_NORMALISE_SAVE_COUNT_B: next_count_b = norm_count_q;
			default: next_count_a = shift_count_reg_a;
		endcase
	end

	// Both count registers share one process because their loads are decoded together.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_count_reg_a <= asd_pkg::RESET_COUNT;
			shift_count_reg_b <= asd_pkg::RESET_COUNT;
		end else begin
			shift_count_reg_a <= next_count_a;
			shift_count_reg_b <= next_count_b;
		end
	end

	// Barrel shifter for the incoming instruction; port-count ops use the value latched now.
	assign next_norm_count = norm_count(shift_in);
	assign is_normalise = (shift_instr == asd_pkg::SHF_NORMALISE_ONLY)
		|| (shift_instr == asd_pkg::SHF_NORMALISE_SAVE_COUNT_A)
		|| (shift_instr == asd_pkg::SHF_NORMALISE_SAVE_COUNT_B);

	// Shift amount source; count ops see a count loaded at this very edge.
	// Reading the next count value lets a load be followed back to back by its use.
	always_comb begin
		unique case (shift_instr)
			asd_pkg::SHF_LOGICAL_RIGHT_BY_COUNT_A,
			asd_pkg::SHF_ARITH_RIGHT_BY_COUNT_A: shift_amount = next_count_a;
			asd_pkg::SHF_ARITH_RIGHT_BY_COUNT_B: shift_amount = next_count_b;
			asd_pkg::SHF_NORMALISE_ONLY, asd_pkg::SHF_NORMALISE_SAVE_COUNT_A,
			asd_pkg::SHF_NORMALISE_SAVE_COUNT_B: shift_amount = next_norm_count;
			default: shift_amount = shift_value_port_in;
		endcase
	end

	// Doubling the word turns a rotate into a plain shift of a wider value.
	assign rot_right_word = {shift_in, shift_in} >> shift_amount;
	assign rot_left_word = {shift_in, shift_in} << shift_amount;

	// Result select; the unused codes five to seven fall to the default pass.
	always_comb begin
		unique case (shift_instr)
			asd_pkg::SHF_LOGICAL_RIGHT_BY_PORT_COUNT:
				next_shift_result = shift_in >> shift_amount;
			asd_pkg::SHF_SHIFT_LEFT_BY_PORT_COUNT:
				next_shift_result = shift_in << shift_amount;
			asd_pkg::SHF_ROTATE_RIGHT_BY_PORT_COUNT:
				next_shift_result = rot_right_word[15:0];
			asd_pkg::SHF_ROTATE_LEFT_BY_PORT_COUNT:
				next_shift_result = rot_left_word[31:16];
			asd_pkg::SHF_LOGICAL_RIGHT_BY_COUNT_A:
				next_shift_result = shift_in >> shift_amount;
			asd_pkg::SHF_ARITH_RIGHT_BY_PORT_COUNT, asd_pkg::SHF_ARITH_RIGHT_BY_COUNT_A,
			asd_pkg::SHF_ARITH_RIGHT_BY_COUNT_B:
				next_shift_result = 16'($signed(shift_in) >>> shift_amount);
			asd_pkg::SHF_NORMALISE_ONLY, asd_pkg::SHF_NORMALISE_SAVE_COUNT_A,
			asd_pkg::SHF_NORMALISE_SAVE_COUNT_B:
				next_shift_result = shift_in << shift_amount;
			default:
				next_shift_result = shift_in;
		endcase
	end

	// The stored result feeds the shifter register file load at the next edge.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_result_q <= asd_pkg::RESET_DATA;
		end else begin
			shift_result_q <= next_shift_result;
		end
	end

	// Port drive is decided at the opening edge and holds for the whole normalise cycle.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_value_port_out <= asd_pkg::RESET_COUNT;
			shift_value_port_oe <= 1'b0;
		end else begin
			shift_value_port_out <= next_norm_count;
			shift_value_port_oe <= is_normalise && !shift_value_out_enable_n
				&& ctrl_drive_allow;
		end
	end

	// One register file behind the ALU and one behind the shifter.
	// Each file gets the stored result for loads and the fresh result for pass-through.
	asd_reg_file u_alu_rf (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.instr_next(alu_rf_instr),
		.instr_q(alu_rf_ir),
		.data_q(alu_result_q),
		.data_next(next_alu_result),
		.rf_out(alu_rf_out)
	);

	asd_reg_file u_shift_rf (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.instr_next(shift_rf_instr),
		.instr_q(shift_rf_ir),
		.data_q(shift_result_q),
		.data_next(next_shift_result),
		.rf_out(shift_rf_out)
	);

	// AHB-Lite slave with no wait states; unmapped reads give zero, writes are dropped.
	assign bus_read_req = hsel && hready && (htrans == asd_pkg::HTRANS_NONSEQ) && !hwrite;
	assign bus_write_req = hsel && hready && (htrans == asd_pkg::HTRANS_NONSEQ) && hwrite;
	// A read right behind a write to the control word sees the value being written.
	assign ctrl_view = (wr_pending && (wr_addr == asd_pkg::ADDR_CTRL))
		? hwdata[asd_pkg::CTRL_DRIVE_ALLOW_BIT] : ctrl_drive_allow;

	always_comb begin
		read_value = asd_pkg::BUS_ZERO;
		if (haddr == asd_pkg::ADDR_CTRL) begin
			read_value[asd_pkg::CTRL_DRIVE_ALLOW_BIT] = ctrl_view;
		end else if (haddr == asd_pkg::ADDR_STATUS) begin
			read_value[asd_pkg::STAT_SV_LSB +: 4] = sv_reg;
			read_value[asd_pkg::STAT_COUNT_A_LSB +: 4] = shift_count_reg_a;
			read_value[asd_pkg::STAT_COUNT_B_LSB +: 4] = shift_count_reg_b;
			read_value[asd_pkg::STAT_FLAG_MODE_LSB +: 4] = flag_mode;
			read_value[asd_pkg::STAT_FLAG_BIT] = condition_flag_out;
			read_value[asd_pkg::STAT_SV_DRIVE_BIT] = shift_value_port_oe;
		end
	end

	// Bus state; write data arrives a cycle after its address, so the address is kept.
	// The slave never stalls, which keeps the master logic trivial.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_pending <= 1'b0;
			wr_addr <= asd_pkg::BUS_ZERO;
			hrdata <= asd_pkg::BUS_ZERO;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pending <= bus_write_req;
			if (bus_write_req) begin
				wr_addr <= haddr;
			end
			if (bus_read_req) begin
				hrdata <= read_value;
			end
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Software may stop the port from ever being driven, even in normalise.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_drive_allow <= asd_pkg::CTRL_DRIVE_ALLOW_RESET;
		end else if (wr_pending && (wr_addr == asd_pkg::ADDR_CTRL)) begin
			ctrl_drive_allow <= hwdata[asd_pkg::CTRL_DRIVE_ALLOW_BIT];
		end
	end
endmodule

// file: src/asd_reg_file.sv
`timescale 1ns/100ps
// Two-register scratchpad; output is registered so it is valid from the opening edge.
module asd_reg_file (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [2:0] instr_next,
	input wire logic [2:0] instr_q,
	input wire logic [15:0] data_q,
	input wire logic [15:0] data_next,
	output logic [15:0] rf_out
);
	logic [15:0] left_reg;
	logic [15:0] right_reg;
	logic [15:0] next_left;
	logic [15:0] next_right;

	// Loads happen at the closing edge of the executing instruction.
	always_comb begin
		next_left = left_reg;
		next_right = right_reg;
		unique case (instr_q)
			asd_pkg::RF_LOAD_LEFT_SHOW_RIGHT: next_left = data_q;
			asd_pkg::RF_LOAD_RIGHT_SHOW_LEFT: next_right = data_q;
			asd_pkg::RF_LOAD_LEFT_SHOW_LEFT: next_left = data_q;
			asd_pkg::RF_LOAD_RIGHT_SHOW_RIGHT: next_right = data_q;
			asd_pkg::RF_LOAD_BOTH_SHOW_LEFT: begin
				next_left = data_q;
				next_right = data_q;
			end
			asd_pkg::RF_HOLD_SHOW_RIGHT, asd_pkg::RF_HOLD_SHOW_LEFT,
			asd_pkg::RF_HOLD_PASS_THROUGH: begin
				next_left = left_reg;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			left_reg <= asd_pkg::RESET_DATA;
			right_reg <= asd_pkg::RESET_DATA;
		end else begin
			left_reg <= next_left;
			right_reg <= next_right;
		end
	end

	// The output for the instruction just latched uses the contents as updated at this edge.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rf_out <= asd_pkg::RESET_DATA;
		end else begin
			unique case (instr_next)
				asd_pkg::RF_LOAD_LEFT_SHOW_RIGHT, asd_pkg::RF_LOAD_RIGHT_SHOW_RIGHT,
				asd_pkg::RF_HOLD_SHOW_RIGHT: rf_out <= next_right;
				asd_pkg::RF_LOAD_RIGHT_SHOW_LEFT, asd_pkg::RF_LOAD_LEFT_SHOW_LEFT,
				asd_pkg::RF_LOAD_BOTH_SHOW_LEFT, asd_pkg::RF_HOLD_SHOW_LEFT: rf_out <= next_left;
				asd_pkg::RF_HOLD_PASS_THROUGH: rf_out <= data_next;
			endcase
		end
	end
endmodule

// file: test/asd_alu_shifter_asserts.sv
`timescale 1ns/100ps
// Port-level checks; the up flags mask the edges whose history still sits in reset.
module asd_alu_shifter_chk (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [4:0] alu_instr,
	input wire logic [3:0] shift_instr,
	input wire logic [2:0] alu_rf_instr,
	input wire logic [2:0] shift_rf_instr,
	input wire logic [15:0] shift_in,
	input wire logic [3:0] shift_value_port_in,
	input wire logic shift_value_port_oe,
	input wire logic shift_value_out_enable_n,
	input wire logic [15:0] alu_rf_out,
	input wire logic [15:0] shift_rf_out,
	input wire logic condition_flag_out
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	logic up;
	logic up2;

	// Counts edges since reset release.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			up <= 1'b0;
			up2 <= 1'b0;
		end else begin
			up <= 1'b1;
			up2 <= up;
		end
	end

	flag_zero_a: assert property (up && $past(alu_instr) == 5'h1b |-> condition_flag_out)
		else $error("zero select did not raise the flag");
	forced_zero_a: assert property (up && $past(alu_instr) inside {5'h18, 5'h19, 5'h1a, 5'h1b}
		&& $past(alu_rf_instr) == 3'h7 |-> alu_rf_out == 16'h0000)
		else $error("flag select result not zero");
	const_byte_a: assert property (up && $past(alu_instr) == 5'h1d && $past(alu_rf_instr) == 3'h7
		|-> alu_rf_out == 16'h00ff) else $error("byte mask constant wrong");
	const_alt_a: assert property (up && $past(alu_instr) == 5'h1f && $past(alu_rf_instr) == 3'h7
		|-> alu_rf_out == 16'h5555) else $error("alternating constant wrong");
	shift_lsr_a: assert property (up && $past(shift_instr) == 4'h0 && $past(shift_rf_instr) == 3'h7
		|-> shift_rf_out == ($past(shift_in) >> $past(shift_value_port_in)))
		else $error("logical right shift wrong");
	count_pass_a: assert property (up && $past(shift_instr) inside {4'h8, 4'h9}
		&& $past(shift_rf_instr) == 3'h7 |-> shift_rf_out == $past(shift_in))
		else $error("count load did not pass data");
	norm_drive_a: assert property (up && shift_value_port_oe |-> !$past(shift_value_out_enable_n)
		&& $past(shift_instr) inside {4'hd, 4'he, 4'hf}) else $error("port driven outside normalise");
	never_drive_a: assert property (up && $past(shift_value_out_enable_n) |-> !shift_value_port_oe)
		else $error("port driven while enable high");
	hold_regs_a: assert property (up2 && $past(shift_rf_instr) == 3'h5 && $past(shift_rf_instr, 2) == 3'h5
		|-> $stable(shift_rf_out)) else $error("hold changed register");

	cover property (up && shift_value_port_oe);
	cover property (up && $past(alu_instr) == 5'h1b && condition_flag_out);
	cover property (up2 && $past(shift_rf_instr, 2) == 3'h5 && $past(shift_rf_instr) == 3'h5);
endmodule

bind asd_alu_shifter asd_alu_shifter_chk asd_alu_shifter_chk_inst (.sys_clk, .arst_n, .alu_instr,
	.shift_instr, .alu_rf_instr, .shift_rf_instr, .shift_in, .shift_value_port_in, .shift_value_port_oe,
	.shift_value_out_enable_n, .alu_rf_out, .shift_rf_out, .condition_flag_out);

// file: test/asd_sv_partner.sv
`timescale 1ns/100ps
// Far-side model of the shift-value pin: resolves the wire from both drivers.
module asd_sv_partner (
	input wire logic sys_clk,
	input wire logic [3:0] dev_out,
	input wire logic dev_oe,
	input wire logic [3:0] host_val,
	input wire logic host_drive,
	output logic [3:0] level
);
	logic [3:0] last = 4'h0;

	// A released pin shows the inverse of its last level, so a stale read never matches.
	always_ff @(posedge sys_clk) begin
		last <= level;
	end

	// The host lets go whenever the device may drive; the device wins the pin when enabled.
	always_comb begin
		level = dev_oe ? dev_out : (host_drive ? host_val : ~last);
	end
endmodule

// file: test/tb_asd_alu_shifter.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin $display("wrong value %s exp %h got %h", nm, e, g); fail_count++; end end
module tb_asd_alu_shifter;
	logic sys_clk = 0, arst_n = 0, alu_core_carry_into_msb = 0, alu_core_carry_out = 0;
	logic [4:0] alu_instr = 5'h16, a_i;
	logic [3:0] shift_instr = 4'h7, s_i, sv_v, shift_value_port_in, shift_value_port_out, host_val = 0;
	logic [2:0] alu_rf_instr = 3'h6, shift_rf_instr = 3'h6, ar, sr, hsize = 3'b010;
	logic [15:0] alu_core_result = 0, shift_in = 0, a_r = 0, s_x = 0, alu_rf_out, shift_rf_out, d, e;
	logic [1:0] htrans = 0, a_c = 0;
	logic host_drive = 1, sv_d = 1, en = 1, shift_value_out_enable_n = 1, shift_value_port_oe;
	logic condition_flag_out, hsel = 0, hwrite = 0, hreadyout, hresp;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [15:0] cv [8] = '{0, 0, 0, 0, 16'h0001, 16'h00ff, 16'h000f, 16'h5555};
	logic [15:0] fr [8] = '{16'h1234, 16'h1234, 16'h4000, 16'h2000, 16'h2000, 16'h1000, 0, 1};
	logic [3:0] so [8] = '{0, 1, 2, 3, 4, 10, 11, 12};
	logic [2:0] rc [13] = '{4, 0, 1, 5, 5, 6, 2, 3, 7, 6, 1, 0, 5};
	logic [15:0] lr [2], rr [2] = '{0, 0};
	int fail_count = 0, cmp_count = 0;

	asd_alu_shifter asd_alu_shifter_inst (.sys_clk, .arst_n, .alu_instr, .shift_instr, .alu_rf_instr,
		.shift_rf_instr, .alu_core_result, .alu_core_carry_into_msb, .alu_core_carry_out, .shift_in,
		.shift_value_port_in, .shift_value_port_out, .shift_value_port_oe, .shift_value_out_enable_n,
		.alu_rf_out, .shift_rf_out, .condition_flag_out, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata);
	asd_sv_partner asd_sv_partner_inst (.sys_clk, .dev_out(shift_value_port_out),
		.dev_oe(shift_value_port_oe), .host_val, .host_drive, .level(shift_value_port_in));

	initial forever #25 sys_clk = ~sys_clk;

	// Presents one instruction word after an edge; it is latched at the next edge.
	task go;
		@(posedge sys_clk);
		alu_instr <= a_i;
		alu_core_result <= a_r;
		{alu_core_carry_into_msb, alu_core_carry_out} <= a_c;
		shift_instr <= s_i;
		shift_in <= s_x;
		host_val <= sv_v;
		host_drive <= sv_d;
		shift_value_out_enable_n <= en;
		alu_rf_instr <= ar;
		shift_rf_instr <= sr;
		@(posedge sys_clk);
		#1;
	endtask

	// One single AHB-Lite transfer; read data lands in rd.
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= asd_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	function automatic logic [3:0] nc(input logic [15:0] x);
		logic [3:0] n;
		n = 0;
		for (int i = 14; i >= 0 && x[i] == x[15]; i--) n++;
		return n;
	endfunction

	function automatic logic [15:0] shf(input logic [3:0] op, input logic [15:0] x, input logic [3:0] n);
		case (op)
			4'h0, 4'h4: return x >> n;
			4'h1, 4'hd, 4'he, 4'hf: return x << n;
			4'h2: return (x >> n) | (x << (16 - n));
			4'h3: return (x << n) | (x >> (16 - n));
			4'ha, 4'hb, 4'hc: return $signed(x) >>> n;
			default: return x;
		endcase
	endfunction

	task test_done;
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Watchdog: the whole sequence needs well under a thousand cycles.
	initial begin
		#200000;
		fail_count++;
		test_done;
	end

	initial begin
		{a_i, s_i, sv_v, ar, sr} = {5'h16, 4'h7, 4'h0, 3'h7, 3'h7};
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		ahb(0, asd_pkg::ADDR_CTRL, 0);
		`CHK("ctrl", 32'h0000_0001, rd)
		`CHK("resp", 1'b0, hresp)
		ahb(0, asd_pkg::ADDR_STATUS, 0);
		`CHK("status", 12'h100, rd[15:4])
		ahb(0, 32'h0000_0010, 0);
		`CHK("unmapped", asd_pkg::BUS_ZERO, rd)
		$display("test 1 done");
		for (int i = 0; i < 8; i++) begin
			a_i = 5'h18 + 5'(i);
			go;
			`CHK("alu const", cv[i], alu_rf_out)
			`CHK("flag", a_i == 5'h1b, condition_flag_out)
		end
		for (int m = 0; m < 4; m++) begin
			a_i = 5'h18 + 5'(m);
			a_c = 0;
			go;
			a_i = 5'h08;
			for (int j = 0; j < 2; j++) begin
				a_r = fr[2 * m + j];
				a_c = (m == 0) ? {1'b1, j == 1} : 2'b00;
				go;
				`CHK("alu pass", a_r, alu_rf_out)
				`CHK("flag mode", j == 0, condition_flag_out)
			end
		end
		$display("test 2 done");
		{s_i, sv_v, s_x} = {4'h8, 4'h5, 16'h9a5c};
		go;
		`CHK("load pass", s_x, shift_rf_out)
		{s_i, sv_v} = {4'h9, 4'h9};
		go;
		ahb(0, asd_pkg::ADDR_STATUS, 0);
		`CHK("counts", 8'h95, rd[11:4])
		for (int k = 0; k < 16; k++) begin
			s_i = so[k % 8];
			sv_v = (k < 8) ? 4'h3 : 4'hf;
			d = shf(s_i, s_x, (s_i == 4 || s_i == 11) ? 4'h5 : (s_i == 12) ? 4'h9 : sv_v);
			go;
			`CHK("shift", d, shift_rf_out)
		end
		$display("test 3 done");
		{sv_d, en} = 2'b00;
		for (int k = 0; k < 3; k++) begin
			s_i = 4'hd + 4'(k);
			s_x = (k == 0) ? 16'h0100 : (k == 1) ? 16'hfff0 : 16'h0000;
			go;
			`CHK("normalise", shf(s_i, s_x, nc(s_x)), shift_rf_out)
			`CHK("port oe", 1'b1, shift_value_port_oe)
			`CHK("port count", nc(s_x), shift_value_port_out)
		end
		ahb(0, asd_pkg::ADDR_STATUS, 0);
		`CHK("norm counts", 8'hfb, rd[11:4])
		{en, s_i} = {1'b1, 4'hd};
		go;
		`CHK("port idle", 1'b0, shift_value_port_oe)
		ahb(1, asd_pkg::ADDR_CTRL, 0);
		en = 0;
		go;
		`CHK("port gated", 1'b0, shift_value_port_oe)
		ahb(1, asd_pkg::ADDR_CTRL, 1);
		{en, sv_d, s_i, a_i} = {1'b1, 1'b1, 4'h7, 5'h16};
		$display("test 4 done");
		lr = '{0, 0};
		for (int i = 0; i < 13; i++) begin
			d = 16'h1000 + 16'(i * 16'h0111);
			{a_r, s_x, ar, sr} = {d, ~d, rc[i], rc[i]};
			go;
			for (int f = 0; f < 2; f++) begin
				e = (ar == 0 || ar == 3 || ar == 5) ? rr[f] : (ar == 7 ? (f ? ~d : d) : lr[f]);
				`CHK("reg file", e, (f ? shift_rf_out : alu_rf_out))
				if (ar inside {0, 2, 4}) lr[f] = f ? ~d : d;
				if (ar inside {1, 3, 4}) rr[f] = f ? ~d : d;
			end
		end
		$display("test 5 done");
		test_done;
	end
endmodule
